//--- switch_monitor_pkg.sv
// Constants shared by the switch monitor serial command front end.
// Assumes a 24-bit command/status frame and 8 dual plus 14 ground inputs.
package switch_monitor_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int          WORD_BITS     = 24;
  localparam int          DUAL_COUNT    = 8;
  localparam int          GROUND_COUNT  = 14;
  localparam int          SYNC_BITS     = 5 + DUAL_COUNT + GROUND_COUNT;
  localparam logic [5:0]  COUNT_ONE     = 6'h01;
  localparam logic [5:0]  COUNT_SAT     = 6'h3f;
  localparam logic [5:0]  COUNT_SINGLE  = 6'h18;  // One device, 24 clocks.
  localparam logic [5:0]  COUNT_CHAIN   = 6'h30;  // Two chained devices, 48 clocks.

  // ----------------------------------------------------------------
  // Command field and opcodes
  // ----------------------------------------------------------------
  localparam int          OP_MSB        = 23;
  localparam int          OP_LSB        = 16;
  localparam logic [7:0]  OP_POLARITY   = 8'h01;
  localparam logic [7:0]  OP_WAKE_DUAL  = 8'h02;
  localparam logic [7:0]  OP_WAKE_GND   = 8'h03;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int          ST_INT_POS    = 23;
  localparam int          ST_THERM_POS  = 22;
  localparam int          ST_DUAL_LSB   = 14;
  localparam int          ST_GND_LSB    = 0;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0]  POLARITY_RESET  = 8'hff;
  localparam logic [7:0]  WAKE_DUAL_RESET = 8'hff;
  localparam logic [13:0] WAKE_GND_RESET  = 14'h3fff;
  localparam logic [23:0] WORD_RESET      = 24'h00_0000;
  // Synchronisers start at idle levels: comparators open, attention pin high and
  // wake pin low as pulled in Normal, so leaving reset shows no false change.
  localparam logic [SYNC_BITS-1:0] SYNC_RESET = 27'h080_3FFF;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic {
    MODE_SLEEP  = 1'b0,
    MODE_NORMAL = 1'b1
  } mode_e;

endpackage

//--- switch_monitor_spi_control.sv
// Serial command interpreter and status front end of a 22-input switch monitor.
// Assumes the host keeps the serial clock low whenever chip select moves, and
// leaves at least 20 ns between chip select falling and the first clock rise.
//
// Behaviour
// R01 - A complete transfer is exactly 24 clock periods with chip select low.
// R02 - Status shifts out on the serial output while the command shifts in.
// R03 - Every reply carries switch states, interrupt flag and thermal flag.
// R04 - Switch states are captured into the reply at chip select falling.
// R05 - Host keeps the serial clock at or below 6.0 MHz; the bench host clocks 48 ns per bit, about 20.8 MHz.
// R06 - Two chained devices need 48 clock periods per transfer.
// R07 - Losing the I/O supply never changes the operating mode.
// R08 - Without I/O supply, serial commands and pin wake-ups are ignored; a wake pin fall still enters Normal here.
// R09 - Battery power-on reset leaves the device in Normal mode.
// R10 - Reset gives switch-to-supply polarity and all inputs wake-capable.
// R11 - Normal mode entered on enabled change, wake, attention, select or timer.
// R12 - Register writes act only in Normal mode with the I/O supply present.
// R13 - Attention releases at select rising unless a switch changed during the frame.
// R14 - Opcode 0x01 loads bits 7 to 0 as dual input polarity.
// R15 - A closed dual input always reads as one.
// R16 - Above threshold is closed for supply polarity, open otherwise.
// R17 - Fourteen ground-only inputs plus eight dual inputs are monitored.
// R18 - A zero enable bit blocks that input from attention and wake.
// R19 - Opcodes 0x02 and 0x03 load dual and ground wake enables.
// R20 - Host may rewrite polarity and enables any time in Normal mode.
// R21 - The thermal flag is live whenever the device is in Normal mode.
// R22 - Input bits sampled on falling clock, output bits change on rising.
// R23 - Command and status words move most significant bit first.
// R24 - Commands act at chip select rising, which also floats the output.
// R25 - Unknown opcodes are discarded with no register change.

`timescale 1ns/1ps

module switch_monitor_spi_control (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_b,
  input  wire logic        i_si,
  input  wire logic [7:0]  i_dual_polarity_input,
  input  wire logic [13:0] i_ground_only_input,
  input  wire logic        i_overtemp,
  input  wire logic        i_io_supply,
  input  wire logic        i_wake_b,
  input  wire logic        i_att_req_b,
  input  wire logic        i_sleep_req,
  input  wire logic        i_int_timer_expired,
  output logic             o_so,
  output logic             o_so_oe_b,
  output logic             o_att_req_b,
  output logic             o_att_req_oe_b,
  output logic             o_wake_b,
  output logic             o_wake_oe_b,
  output logic             o_normal_mode,
  output logic [7:0]       o_input_polarity_select,
  output logic [7:0]       o_wake_enable_dual_inputs,
  output logic [13:0]      o_wake_enable_ground_inputs
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int SB = switch_monitor_pkg::SYNC_BITS;

  // Every check in this module runs on the core clock and rests during reset.
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  logic                     cs_fall_tog;
  logic                     rx_tog;
  logic [5:0]               rx_count;
  logic [23:0]              rx_word;
  logic                     tx_tog;
  logic [23:0]              tx_word;
  logic                     so;
  logic [23:0]              cmd_hold;
  logic                     cmd_complete;
  logic                     cmd_tog;
  logic                     cs_s1;
  logic                     cs_s2;
  logic                     cs_q;
  logic [SB-1:0]            pin_s1;
  logic [SB-1:0]            pin_s2;
  logic [SB-1:0]            pin_q;
  logic [7:0]               dual_cmp;
  logic [13:0]              gnd_cmp;
  logic [7:0]               closed_dual;
  logic [13:0]              closed_gnd;
  logic [21:0]              closed_prev;
  logic                     enabled_change;
  logic                     wake_fall;
  logic                     att_fall;
  logic                     cs_fall;
  logic                     cs_rise;
  logic                     cmd_fire;
  logic                     write_ok;
  logic                     wake_event;
  logic                     thermal;
  switch_monitor_pkg::mode_e mode;
  switch_monitor_pkg::mode_e next_mode;
  logic                     chg_in_frame;
  logic                     att_oe_b;
  logic                     next_int_pend;
  logic                     int_pend;
  logic [23:0]              status_snap;
  logic                     so_oe_b;
  logic                     wake_oe_b;
  logic [7:0]               input_polarity_select;
  logic [7:0]               wake_enable_dual_inputs;
  logic [13:0]              wake_enable_ground_inputs;
  logic [7:0]               opcode;

  // ----------------------------------------------------------------
  // Link side: chip select and serial clock domains
  // ----------------------------------------------------------------

  // Each chip select fall flips this marker; the serial clock logic sees a new
  // frame when its own copy differs. The clock is idle here, so no sync exists.
  always_ff @(negedge i_cs_b or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_fall_tog <= 1'b0;
    end else begin
      cs_fall_tog <= ~cs_fall_tog;
    end
  end

  // Receive shifter samples the serial input on the falling clock, MSB first.
  always_ff @(negedge i_sclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_tog   <= 1'b0;
      rx_count <= 6'h00;
      rx_word  <= switch_monitor_pkg::WORD_RESET;
    end else begin
      rx_word <= {rx_word[22:0], i_si};                      // R22 R23
      if (rx_tog != cs_fall_tog) begin
        rx_tog   <= cs_fall_tog;
        rx_count <= switch_monitor_pkg::COUNT_ONE;
      end else if (rx_count != switch_monitor_pkg::COUNT_SAT) begin
        rx_count <= rx_count + switch_monitor_pkg::COUNT_ONE;  // R01
      end
    end
  end

  // Transmit shifter loads the captured status on the first rising clock and
  // then passes received bits on, so a second device in a chain sees them.
  always_ff @(posedge i_sclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_tog  <= 1'b0;
      tx_word <= switch_monitor_pkg::WORD_RESET;
      so      <= 1'b0;
    end else if (tx_tog != cs_fall_tog) begin
      tx_tog  <= cs_fall_tog;
      tx_word <= status_snap;                                // R02
      so      <= status_snap[23];                            // R23
    end else begin
      tx_word <= {tx_word[22:0], rx_word[0]};                // R06
      so      <= tx_word[22];                                // R22
    end
  end

  // The finished frame is frozen at chip select rising; the clock is stopped
  // then, so count and word are steady. Chained frames of 48 are accepted.
  always_ff @(posedge i_cs_b or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmd_hold     <= switch_monitor_pkg::WORD_RESET;
      cmd_complete <= 1'b0;
      cmd_tog      <= 1'b0;
    end else begin
      cmd_hold     <= rx_word;                               // R24
      cmd_complete <= (rx_tog == cs_fall_tog) &&
                      ((rx_count == switch_monitor_pkg::COUNT_SINGLE) ||
                       (rx_count == switch_monitor_pkg::COUNT_CHAIN));  // R01 R06
      cmd_tog      <= ~cmd_tog;
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers into the reference clock domain
  // ----------------------------------------------------------------

  // Chip select resets high so the output stays floating out of reset.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_q  <= 1'b1;
    end else begin
      cs_s1 <= i_cs_b;
      cs_s2 <= cs_s1;
      cs_q  <= cs_s2;
    end
  end

  // Pins and the command toggle pass two flops; a third copy finds edges.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_s1 <= switch_monitor_pkg::SYNC_RESET;
      pin_s2 <= switch_monitor_pkg::SYNC_RESET;
      pin_q  <= switch_monitor_pkg::SYNC_RESET;
    end else begin
      pin_s1 <= {cmd_tog, i_overtemp, i_io_supply, i_att_req_b, i_wake_b,
                 i_dual_polarity_input, i_ground_only_input};
      pin_s2 <= pin_s1;
      pin_q  <= pin_s2;
    end
  end

  assign gnd_cmp   = pin_s2[13:0];
  assign dual_cmp  = pin_s2[21:14];
  assign wake_fall = pin_q[22] & ~pin_s2[22];
  assign att_fall  = pin_q[23] & ~pin_s2[23];
  assign cs_fall   = cs_q & ~cs_s2;
  assign cs_rise   = ~cs_q & cs_s2;
  assign cmd_fire  = pin_q[26] ^ pin_s2[26];

  // ----------------------------------------------------------------
  // Switch state judgement
  // ----------------------------------------------------------------

  // A comparator high means above threshold; polarity decides what closed is.
  genvar gi;
  generate
    for (gi = 0; gi < switch_monitor_pkg::DUAL_COUNT; gi++) begin : g_dual
      assign closed_dual[gi] = input_polarity_select[gi] ? dual_cmp[gi]
                                                         : ~dual_cmp[gi];  // R15 R16
    end
  endgenerate

  assign closed_gnd = ~gnd_cmp;                              // R16 R17

  // Only inputs with their enable bit set may raise attention or wake.
  assign enabled_change = |(({closed_dual, closed_gnd} ^ closed_prev) &
                           {wake_enable_dual_inputs, wake_enable_ground_inputs});  // R18 R19

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      closed_prev <= 22'h00_0000;
    end else begin
      closed_prev <= {closed_dual, closed_gnd};
    end
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------

  // Select and attention wake-ups need the I/O supply; supply loss itself is
  // never an event, so the mode holds across it.
  assign wake_event = enabled_change | wake_fall | i_int_timer_expired |
                      (att_fall & pin_s2[24] & pin_s2[22]) |
                      (cs_fall & pin_s2[24]);                // R11 R08 R07

  always_comb begin
    next_mode = mode;
    unique case (mode)
      switch_monitor_pkg::MODE_SLEEP: begin
        if (wake_event) begin
          next_mode = switch_monitor_pkg::MODE_NORMAL;      // R11
        end
      end
      switch_monitor_pkg::MODE_NORMAL: begin
        if (i_sleep_req) begin
          next_mode = switch_monitor_pkg::MODE_SLEEP;
        end
      end
    endcase
  end

  // Power-on reset lands in Normal mode.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode <= switch_monitor_pkg::MODE_NORMAL;               // R09
    end else begin
      mode <= next_mode;
    end
  end

  // The wake pin is pulled low in Normal mode to hold the supply enabled.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wake_oe_b <= 1'b0;
    end else begin
      wake_oe_b <= (next_mode == switch_monitor_pkg::MODE_SLEEP);
    end
  end

  assign thermal = (mode == switch_monitor_pkg::MODE_NORMAL) & pin_s2[25];  // R21

  // ----------------------------------------------------------------
  // Attention request
  // ----------------------------------------------------------------

  // A change seen while select is low keeps attention past the next rising
  // edge, so the host never misses it. Setting wins over the clear.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      chg_in_frame <= 1'b0;
    end else if (enabled_change && !cs_s2 && (mode == switch_monitor_pkg::MODE_NORMAL)) begin
      chg_in_frame <= 1'b1;
    end else if (cs_rise) begin
      chg_in_frame <= 1'b0;
    end
  end

  assign int_pend      = ~att_oe_b;
  assign next_int_pend = ((mode == switch_monitor_pkg::MODE_NORMAL) & enabled_change) |
                         (int_pend & ~(cs_rise & ~chg_in_frame));  // R13 R18 R19

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      att_oe_b <= 1'b1;
    end else begin
      att_oe_b <= ~next_int_pend;
    end
  end

  // ----------------------------------------------------------------
  // Status capture and output enable
  // ----------------------------------------------------------------

  // The snapshot is held for the whole frame, so the serial clock side may
  // read it directly.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_snap <= switch_monitor_pkg::WORD_RESET;
    end else if (cs_fall) begin
      status_snap <= {int_pend, thermal, closed_dual, closed_gnd};  // R03 R04
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      so_oe_b <= 1'b1;
    end else begin
      so_oe_b <= cs_s2;                                      // R24
    end
  end

  // ----------------------------------------------------------------
  // Command decode and registers
  // ----------------------------------------------------------------
  assign opcode   = cmd_hold[switch_monitor_pkg::OP_MSB:switch_monitor_pkg::OP_LSB];
  assign write_ok = cmd_fire & cmd_complete & pin_s2[24] &
                    (mode == switch_monitor_pkg::MODE_NORMAL);  // R12 R08 R20

  // Unknown opcodes fall through here untouched.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      input_polarity_select     <= switch_monitor_pkg::POLARITY_RESET;   // R10
      wake_enable_dual_inputs   <= switch_monitor_pkg::WAKE_DUAL_RESET;  // R10
      wake_enable_ground_inputs <= switch_monitor_pkg::WAKE_GND_RESET;   // R10
    end else if (write_ok) begin
      if (opcode == switch_monitor_pkg::OP_POLARITY) begin
        input_polarity_select <= cmd_hold[7:0];              // R14
      end
      if (opcode == switch_monitor_pkg::OP_WAKE_DUAL) begin
        wake_enable_dual_inputs <= cmd_hold[7:0];            // R19
      end
      if (opcode == switch_monitor_pkg::OP_WAKE_GND) begin
        wake_enable_ground_inputs <= cmd_hold[13:0];         // R19 R25
      end
    end
  end

  // Open-drain pins only ever pull low.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_att_req_b <= 1'b0;
      o_wake_b    <= 1'b0;
    end else begin
      o_att_req_b <= 1'b0;
      o_wake_b    <= 1'b0;
    end
  end

  assign o_so                        = so;
  assign o_so_oe_b                   = so_oe_b;
  assign o_att_req_oe_b              = att_oe_b;
  assign o_wake_oe_b                 = wake_oe_b;
  assign o_normal_mode               = mode;
  assign o_input_polarity_select     = input_polarity_select;
  assign o_wake_enable_dual_inputs   = wake_enable_dual_inputs;
  assign o_wake_enable_ground_inputs = wake_enable_ground_inputs;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  polarity_load_a: assert property (write_ok && opcode == 8'h01 |=>  // R14
    input_polarity_select == $past(cmd_hold[7:0]))
    else $error("polarity not loaded");

  write_gate_a: assert property (cmd_fire && !write_ok |=>  // R12
    $stable(input_polarity_select) && $stable(wake_enable_ground_inputs))
    else $error("register changed without a legal write");

  bad_opcode_a: assert property (write_ok && (opcode == 8'h00 || opcode > 8'h03) |=>  // R25
    $stable({input_polarity_select, wake_enable_dual_inputs, wake_enable_ground_inputs}))
    else $error("unknown opcode changed a register");

  ground_wake_a: assert property (write_ok && opcode == 8'h03 |=>  // R19
    wake_enable_ground_inputs == $past(cmd_hold[13:0]))
    else $error("ground wake enables not loaded");

  att_raise_a: assert property (mode && enabled_change |=> !o_att_req_oe_b)  // R18
    else $error("enabled change did not assert attention");

  att_hold_a: assert property (cs_rise && chg_in_frame |=> !o_att_req_oe_b)  // R13
    else $error("attention released despite change in frame");

  att_release_a: assert property (cs_rise && !chg_in_frame && !enabled_change  // R13
    |=> o_att_req_oe_b)
    else $error("attention not released at select rising");

  snap_capture_a: assert property (cs_fall |=>  // R04
    status_snap[21:0] == $past({closed_dual, closed_gnd}) &&
    status_snap[23] == $past(int_pend))
    else $error("status not captured at select falling");

  thermal_mode_a: assert property (cs_fall && !mode |=> !status_snap[22])  // R21
    else $error("thermal flag outside Normal mode");

  wake_mode_a: assert property (!mode && wake_fall |=> o_normal_mode)  // R11
    else $error("wake pin fall did not enter Normal mode");

  mode_hold_a: assert property (mode && !i_sleep_req |=> o_normal_mode)  // R07
    else $error("Normal mode left without sleep request");

  so_float_a: assert property (cs_rise |=> o_so_oe_b [*2])  // R24
    else $error("serial output driven after select rising");

  cover_polarity_c: cover property (write_ok && opcode == 8'h01);
  cover_att_kept_c: cover property (cs_rise && chg_in_frame);
  cover_wake_c:     cover property (!mode ##1 mode);
  cover_frame_c:    cover property (cs_fall ##[1:400] cs_rise);

endmodule // switch_monitor_spi_control

//--- host_spi_model.sv
// Behavioural host that acts as master on the serial link of the switch monitor.
// Assumes the bench calls xfer and that the device drives the status line.
`timescale 1ns/1ps

module host_spi_model (
  output logic      o_sclk,
  output logic      o_cs_b,
  output logic      o_si,
  input  wire logic i_so
);
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  // The clock idles low and moves only inside a frame.
  // So chip select never changes while the clock is high.
  initial begin
    o_sclk = 1'h0;
    o_cs_b = 1'h1;
    o_si   = 1'h0;
  end

  // Sends the low n bits of w with the most significant first, 48 ns per bit.
  // The status bit is read just before each falling clock edge.
  task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] rsp);
    rsp = '0;
    #3 o_cs_b = 1'h0;
    #48;
    for (int i = n - 1; i >= 0; i--) begin
      #12 o_si = w[i];
      #12 o_sclk = 1'h1;
      #24 rsp = {rsp[46:0], i_so};
      o_sclk = 1'h0;
    end
    #24 o_cs_b = 1'h1;
    o_si = ~o_si;  // A released data line must not keep showing the last bit.
    #100;
  endtask
endmodule // host_spi_model

//--- switch_monitor_spi_control_tb_top.sv
// Self-checking bench for the switch monitor serial command front end.
// Assumes the host model above and pull-ups on the attention and wake pins.
`timescale 1ns/1ps

module switch_monitor_spi_control_tb_top;
  logic        ref_clk, rst_b, sclk, cs_b, si, so, so_oe_b, att_b, att_oe_b;
  logic        wake_b, wake_oe_b, normal, overtemp, io_supply, sleep_req, timer_exp;
  logic [7:0]  dual_in, pol, wd;
  logic [13:0] gnd_in, wg;
  logic [47:0] rsp;
  logic [23:0] cmd_tab [6];
  logic [29:0] exp_tab [6];
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  // Open-drain pins read high unless driven low.
  wire att_pin  = att_oe_b ? 1'h1 : att_b;
  wire wake_pin = wake_oe_b ? 1'h1 : wake_b;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  host_spi_model i_host (.o_sclk(sclk), .o_cs_b(cs_b), .o_si(si), .i_so(so));
  switch_monitor_spi_control i_dut (
    .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_sclk(sclk), .i_cs_b(cs_b), .i_si(si),
    .i_dual_polarity_input(dual_in), .i_ground_only_input(gnd_in),
    .i_overtemp(overtemp), .i_io_supply(io_supply), .i_wake_b(wake_pin),
    .i_att_req_b(att_pin), .i_sleep_req(sleep_req), .i_int_timer_expired(timer_exp),
    .o_so(so), .o_so_oe_b(so_oe_b), .o_att_req_b(att_b), .o_att_req_oe_b(att_oe_b),
    .o_wake_b(wake_b), .o_wake_oe_b(wake_oe_b), .o_normal_mode(normal),
    .o_input_polarity_select(pol), .o_wake_enable_dual_inputs(wd),
    .o_wake_enable_ground_inputs(wg));

  // ----------------------------------------------------------------
  // Clock, timeout and checking helpers
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // About a dozen frames of 1.4 us each fit well inside this ceiling.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input string name, input logic [29:0] seen, input logic [29:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Sends one frame and lets the decode cross into the core clock.
  task automatic frame(input logic [47:0] w, input int n);
    i_host.xfer(w, n, rsp);
    ticks(8);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Rows hold a command and the register set {polarity, dual, ground} it leaves.
  initial begin
    cmd_tab = '{24'h01_FF5A, 24'h02_00C3, 24'h03_EABC, 24'h04_00FF, 24'h7F_FFFF,
                24'h01_0000};
    exp_tab = '{{8'h5A, 8'hFF, 14'h3FFF}, {8'h5A, 8'hC3, 14'h3FFF},
                {8'h5A, 8'hC3, 14'h2ABC}, {8'h5A, 8'hC3, 14'h2ABC},
                {8'h5A, 8'hC3, 14'h2ABC}, {8'h00, 8'hC3, 14'h2ABC}};
    rst_b = 1'h0;
    overtemp = 1'h1;
    io_supply = 1'h1;
    sleep_req = 1'h0;
    timer_exp = 1'h0;
    dual_in = 8'h0F;
    gnd_in = 14'h3FF0;
    ticks(6);
    chk("reset regs", {pol, wd, wg}, {8'hFF, 8'hFF, 14'h3FFF});
    chk("reset mode", 30'(normal), 30'h1);
    chk("reset so_oe", 30'(so_oe_b), 30'h1);
    rst_b = 1'h1;
    ticks(10);
    chk("pins low", 30'({att_pin, wake_pin}), 30'h0);
    // Closed inputs seen after reset raise attention, latched into the reply.
    frame({24'h0, 24'hFF_0000}, 24);
    chk("status", 30'(rsp[23:0]), 30'(24'hC3_C00F));
    chk("att release", 30'(att_oe_b), 30'h1);
    chk("so float", 30'(so_oe_b), 30'h1);
    for (int r = 0; r < 6; r++) begin
      frame({24'h0, cmd_tab[r]}, 24);
      chk("regs row", {pol, wd, wg}, exp_tab[r]);
    end
    frame({24'h0, 24'h02_0000}, 23);
    chk("short frame", 30'(wd), 30'(8'hC3));
    frame({24'hA5_5A3C, 24'h02_0011}, 48);
    chk("chain write", 30'(wd), 30'(8'h11));
    chk("chain pass", 30'(rsp[23:0]), 30'(24'hA5_5A3C));
    chk("chain status", 30'(rsp[47:24]), 30'(24'h7C_000F));
    io_supply = 1'h0;
    frame({24'h0, 24'h02_0022}, 24);
    chk("no io write", 30'(wd), 30'(8'h11));
    chk("no io mode", 30'(normal), 30'h1);
    io_supply = 1'h1;
    sleep_req = 1'h1;
    ticks(1);
    sleep_req = 1'h0;
    ticks(3);
    chk("sleep mode", 30'(normal), 30'h0);
    chk("wake pin", 30'(wake_oe_b), 30'h1);
    timer_exp = 1'h1;
    ticks(1);
    timer_exp = 1'h0;
    ticks(3);
    chk("timer wake", 30'(normal), 30'h1);
    sleep_req = 1'h1;
    ticks(1);
    sleep_req = 1'h0;
    io_supply = 1'h0;
    frame({24'h0, 24'h7F_FFFF}, 24);
    chk("cs no io", 30'(normal), 30'h0);
    io_supply = 1'h1;
    frame({24'h0, 24'h7F_FFFF}, 24);
    chk("cs wake", 30'(normal), 30'h1);
    // A reset in mid-run brings back every default over the written values.
    rst_b = 1'h0;
    ticks(2);
    chk("mid reset regs", {pol, wd, wg}, {8'hFF, 8'hFF, 14'h3FFF});
    chk("mid reset pins", 30'({normal, att_oe_b, so_oe_b}), 30'h7);
    rst_b = 1'h1;
    ticks(2);
    chk("after reset att", 30'(att_oe_b), 30'h1);
    report_and_stop();
  end
endmodule // switch_monitor_spi_control_tb_top
